// ===== hdl/tsc_params.svh
// Purpose: Offsets, field positions, codes and reset values of the
//          trigger state control block.
// Assumes: 32-bit AXI4-Lite data, one aligned word per register.
// Notes:   Definitions only.
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define TSC_OFS_CMD 8'h00
`define TSC_OFS_SRC 8'h04
`define TSC_OFS_PEND_AC 8'h08
`define TSC_OFS_PEND_DC 8'h0C
`define TSC_OFS_PEND_FREQ 8'h10
`define TSC_OFS_OUT_AC 8'h14
`define TSC_OFS_OUT_DC 8'h18
`define TSC_OFS_OUT_FREQ 8'h1C
`define TSC_OFS_STATUS 8'h20
`define TSC_OFS_WAVE 8'h24
`define TSC_OFS_MEAS 8'h28
`define TSC_OFS_ERR 8'h2C

// ==========================================================
// Trigger groups
`define TSC_NGRP 4
`define TSC_G_OUT 0
`define TSC_G_MEAS 1
`define TSC_G_SIM 2
`define TSC_G_SEQ 3

// ==========================================================
// Command register bits (write one to act)
`define TSC_CMD_ARM_LSB 0
`define TSC_CMD_TRIG_LSB 4
`define TSC_CMD_COMMON_TRIG 8
`define TSC_CMD_CANCEL 9
`define TSC_CMD_RESET 10
`define TSC_CMD_RECALL 11
`define TSC_CMD_DEV_CLEAR 12
`define TSC_CMD_MEASURE 13

// ==========================================================
// Status register bits
`define TSC_ST_MEAS_VALID 12
`define TSC_ST_TRIG_ERR 13
`define TSC_ST_FETCH_ERR 14
`define TSC_ST_WAVE_REFUSED 15
`define TSC_ST_SYNC 16

// ==========================================================
// Waveform register fields
`define TSC_WAVE_EN 0
`define TSC_WAVE_TYPE_LSB 4

// ==========================================================
// Error codes and reset values
`define TSC_ERR_TRIGGER 32'hFFFFFF2E
`define TSC_ERR_NO_DATA 32'hFFFFFF1A
`define TSC_ERR_NONE 32'h00000000
`define TSC_RST_WORD 32'h00000000
`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2

`endif

// ===== hdl/tsc_pkg.sv
// Purpose: Types of the trigger state control block.
// Assumes: Constants come from tsc_params.svh.
// Notes:   Nothing is imported; users write tsc_pkg::name.
package tsc_pkg;

   // ==========================================================
   // Trigger group state, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_INIT = 3'h2,
      ST_WAITING_FOR_TRIGGER_STATE = 3'h4
   } tsc_state_e;

   // ==========================================================
   // Waveform type codes as reported
   typedef enum logic [1:0] {
      WAVE_SINE = 2'h0,
      WAVE_CLIP = 2'h1,
      WAVE_FLAT_TOP_SHAPE = 2'h2,
      WAVE_ARB = 2'h3
   } tsc_wave_e;

endpackage : tsc_pkg

// ===== hdl/tsc_trigger_ctrl.sv
// Purpose: Trigger sequencing for four trigger groups with AXI4-Lite
//          register access, pending output settings and measurement hold.
// Assumes: Engines give a one-cycle done pulse per group; aclk 40 MHz.
// Notes:
// Functional notes
// - Four groups: output change, measurement, simulation, sequence.
// - Each group has only idle, initiated and waiting-for-trigger states.
// - Reset places every group in idle.
// - A trigger reaching an idle group is discarded without effect.
// - Cancel, reset, recall or device clear force all groups idle.
// - Arming an idle group moves it out of idle into operation.
// - With no-wait source, arming fires the group at once.
// - With host-trigger source, arming enters the waiting state.
// - A trigger in the waiting state fires the group.
// - Output-change fire applies AC, DC offset and frequency only.
// - Pending AC, DC and frequency copy to output only on fire.
// - Trigger during a running output change flags error -210.
// - Completion of a triggered operation returns the group to idle.
// - Cancel instead of trigger drops pending output changes.
// - Common trigger fires every waiting group at the same time.
// - Cancel and device clear stop measuring but keep held data.
// - Reset and recall invalidate held data; later fetch errors.
// - Measure starts a new measurement; fetch reads held data only.
// - Waveform type reports sine, clipped, flat-top or user table.
// - Custom waveform enable is one bit, refused while sync active.
// - Cancel stops a waiting or running sequence and idles it.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "tsc_params.svh"

module tsc_trigger_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Engine side
   output logic [3:0] grp_start_q,
   output logic [3:0] grp_stop_q,
   input wire logic [3:0] grp_done,
   input wire logic [31:0] meas_value,
   output logic [31:0] out_ac_q,
   output logic [31:0] out_dc_q,
   output logic [31:0] out_freq_q,
   input wire logic sync_active,
   input wire logic [1:0] wave_type,
   output logic wave_enable_q
);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `TSC_OFS_ERR);
   endfunction : mapped

   // ==========================================================
   // Storage
   tsc_pkg::tsc_state_e grp_q [`TSC_NGRP];
   logic [3:0] src_q;
   logic [31:0] pend_ac_q;
   logic [31:0] pend_dc_q;
   logic [31:0] pend_freq_q;
   logic [31:0] meas_data_q;
   logic meas_valid_q;
   logic trig_err_q;
   logic fetch_err_q;
   logic wave_refused_q;
   logic [31:0] err_code_q;

   // ==========================================================
   // AXI4-Lite write channel
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic [31:0] cmd;

   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         wdata_q <= `TSC_RST_WORD;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
         w_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TSC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(awaddr_q) ? `TSC_RESP_OKAY
                                         : `TSC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   function automatic logic wr_at(input logic [7:0] ofs);
      return do_write && (awaddr_q == ofs);
   endfunction : wr_at

   // Command bits live one cycle only; unselected lanes act as zero
   // Decoded in place so the assign sees every operand it depends on
   assign cmd = (do_write && awaddr_q == `TSC_OFS_CMD)
                ? merge(32'h0, wdata_q, wstrb_q) : 32'h0;

   // ==========================================================
   // Command decode
   logic all_idle;
   logic drop_data;
   logic common_trig;
   logic measure_cmd;
   logic [3:0] arm;
   logic [3:0] host_trig;
   logic [3:0] fire;
   logic [3:0] src_eff;

   // Reset and recall are the only causes that also drop held data
   assign drop_data = cmd[`TSC_CMD_RESET] || cmd[`TSC_CMD_RECALL];
   assign all_idle = cmd[`TSC_CMD_CANCEL] || cmd[`TSC_CMD_DEV_CLEAR]
                     || drop_data;
   assign common_trig = cmd[`TSC_CMD_COMMON_TRIG];
   assign measure_cmd = cmd[`TSC_CMD_MEASURE];
   assign host_trig = cmd[`TSC_CMD_TRIG_LSB +: 4];

   always_comb begin
      arm = cmd[`TSC_CMD_ARM_LSB +: 4];
      src_eff = src_q;
      // Measure arms the measurement group without waiting
      arm[`TSC_G_MEAS] = arm[`TSC_G_MEAS] || measure_cmd;
      if (measure_cmd) begin
         src_eff[`TSC_G_MEAS] = 1'b0;
      end
   end

   // ==========================================================
   // Trigger group state machines
   always_comb begin
      for (int g = 0; g < `TSC_NGRP; g++) begin
         fire[g] = 1'b0;
         if (!all_idle) begin
            case (grp_q[g])
               tsc_pkg::ST_IDLE: begin
                  fire[g] = arm[g] && !src_eff[g];
               end
               tsc_pkg::ST_WAITING_FOR_TRIGGER_STATE: begin
                  fire[g] = host_trig[g] || common_trig;
               end
               tsc_pkg::ST_INIT: begin
                  fire[g] = 1'b0;
               end
               default: begin
                  fire[g] = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      for (int g = 0; g < `TSC_NGRP; g++) begin
         if (!aresetn) begin
            grp_q[g] <= tsc_pkg::ST_IDLE;
         end else if (all_idle) begin
            grp_q[g] <= tsc_pkg::ST_IDLE;
         end else begin
            case (grp_q[g])
               tsc_pkg::ST_IDLE: begin
                  // Triggers here fall through unused
                  if (arm[g] && src_eff[g]) begin
                     grp_q[g] <= tsc_pkg::ST_WAITING_FOR_TRIGGER_STATE;
                  end else if (fire[g]) begin
                     grp_q[g] <= tsc_pkg::ST_INIT;
                  end
               end
               tsc_pkg::ST_WAITING_FOR_TRIGGER_STATE: begin
                  if (fire[g]) begin
                     grp_q[g] <= tsc_pkg::ST_INIT;
                  end
               end
               tsc_pkg::ST_INIT: begin
                  if (grp_done[g]) begin
                     grp_q[g] <= tsc_pkg::ST_IDLE;
                  end
               end
               default: begin
                  grp_q[g] <= tsc_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // Start and stop strobes to the engines
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         grp_start_q <= 4'h0;
         grp_stop_q <= 4'h0;
      end else begin
         grp_start_q <= fire;
         for (int g = 0; g < `TSC_NGRP; g++) begin
            // Waiting groups are stopped too so engines never see a start
            grp_stop_q[g] <= all_idle &&
                             (grp_q[g] != tsc_pkg::ST_IDLE);
         end
      end
   end

   // ==========================================================
   // Source selection, one bit per group, 1 = host trigger
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_q <= 4'h0;
      end else if (wr_at(`TSC_OFS_SRC) && wstrb_q[0]) begin
         src_q <= wdata_q[3:0];
      end
   end

   // ==========================================================
   // Pending and applied output settings
   logic drop_pending;
   assign drop_pending = all_idle &&
      (grp_q[`TSC_G_OUT] != tsc_pkg::ST_IDLE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_ac_q <= `TSC_RST_WORD;
         pend_dc_q <= `TSC_RST_WORD;
         pend_freq_q <= `TSC_RST_WORD;
      end else if (drop_pending) begin
         pend_ac_q <= out_ac_q;
         pend_dc_q <= out_dc_q;
         pend_freq_q <= out_freq_q;
      end else begin
         if (wr_at(`TSC_OFS_PEND_AC)) begin
            pend_ac_q <= merge(pend_ac_q, wdata_q, wstrb_q);
         end
         if (wr_at(`TSC_OFS_PEND_DC)) begin
            pend_dc_q <= merge(pend_dc_q, wdata_q, wstrb_q);
         end
         if (wr_at(`TSC_OFS_PEND_FREQ)) begin
            pend_freq_q <= merge(pend_freq_q, wdata_q, wstrb_q);
         end
      end
   end

   // Current limit is not held here, so a trigger cannot touch it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_ac_q <= `TSC_RST_WORD;
         out_dc_q <= `TSC_RST_WORD;
         out_freq_q <= `TSC_RST_WORD;
      end else if (fire[`TSC_G_OUT]) begin
         out_ac_q <= pend_ac_q;
         out_dc_q <= pend_dc_q;
         out_freq_q <= pend_freq_q;
      end
   end

   // ==========================================================
   // Measurement hold
   logic meas_read;
   logic fetch_fail;
   logic trig_busy;
   logic [31:0] status_w1c;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meas_valid_q <= 1'b0;
         meas_data_q <= `TSC_RST_WORD;
      end else if (drop_data || measure_cmd) begin
         meas_valid_q <= 1'b0;
      end else if (grp_done[`TSC_G_MEAS] &&
                   grp_q[`TSC_G_MEAS] == tsc_pkg::ST_INIT) begin
         meas_valid_q <= 1'b1;
         meas_data_q <= meas_value;
      end
   end

   // No held data and nothing on the way means the fetch cannot succeed
   assign fetch_fail = meas_read && !meas_valid_q &&
      (grp_q[`TSC_G_MEAS] == tsc_pkg::ST_IDLE);

   // A second change while one is still applying
   assign trig_busy = (grp_q[`TSC_G_OUT] == tsc_pkg::ST_INIT) &&
      (host_trig[`TSC_G_OUT] || common_trig) && !all_idle;

   // ==========================================================
   // Sticky error flags; a set in the clearing cycle wins
   assign status_w1c = (do_write && awaddr_q == `TSC_OFS_STATUS)
                       ? merge(32'h0, wdata_q, wstrb_q) : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_err_q <= 1'b0;
      end else if (trig_busy) begin
         trig_err_q <= 1'b1;
      end else if (status_w1c[`TSC_ST_TRIG_ERR]) begin
         trig_err_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fetch_err_q <= 1'b0;
      end else if (fetch_fail) begin
         fetch_err_q <= 1'b1;
      end else if (status_w1c[`TSC_ST_FETCH_ERR]) begin
         fetch_err_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_code_q <= `TSC_ERR_NONE;
      end else if (trig_busy) begin
         err_code_q <= `TSC_ERR_TRIGGER;
      end else if (fetch_fail) begin
         err_code_q <= `TSC_ERR_NO_DATA;
      end else if (wr_at(`TSC_OFS_ERR)) begin
         err_code_q <= `TSC_ERR_NONE;
      end
   end

   // ==========================================================
   // Custom waveform enable
   logic wave_wr;
   assign wave_wr = do_write && (awaddr_q == `TSC_OFS_WAVE) && wstrb_q[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wave_enable_q <= 1'b0;
      end else if (wave_wr && !sync_active) begin
         wave_enable_q <= wdata_q[`TSC_WAVE_EN];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wave_refused_q <= 1'b0;
      end else if (wave_wr && sync_active) begin
         wave_refused_q <= 1'b1;
      end else if (status_w1c[`TSC_ST_WAVE_REFUSED]) begin
         wave_refused_q <= 1'b0;
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   logic [31:0] rd_word;
   logic [31:0] status_word;

   assign s_axi_arready = !s_axi_rvalid;
   assign meas_read = s_axi_arvalid && s_axi_arready &&
                      (s_axi_araddr == `TSC_OFS_MEAS);

   always_comb begin
      status_word = 32'h0;
      for (int g = 0; g < `TSC_NGRP; g++) begin
         status_word[g*3 +: 3] = grp_q[g];
      end
      status_word[`TSC_ST_MEAS_VALID] = meas_valid_q;
      status_word[`TSC_ST_TRIG_ERR] = trig_err_q;
      status_word[`TSC_ST_FETCH_ERR] = fetch_err_q;
      status_word[`TSC_ST_WAVE_REFUSED] = wave_refused_q;
      status_word[`TSC_ST_SYNC] = sync_active;
   end

   always_comb begin
      rd_word = 32'h0;
      case (s_axi_araddr)
         `TSC_OFS_SRC: rd_word = {28'h0, src_q};
         `TSC_OFS_PEND_AC: rd_word = pend_ac_q;
         `TSC_OFS_PEND_DC: rd_word = pend_dc_q;
         `TSC_OFS_PEND_FREQ: rd_word = pend_freq_q;
         `TSC_OFS_OUT_AC: rd_word = out_ac_q;
         `TSC_OFS_OUT_DC: rd_word = out_dc_q;
         `TSC_OFS_OUT_FREQ: rd_word = out_freq_q;
         `TSC_OFS_STATUS: rd_word = status_word;
         `TSC_OFS_WAVE: begin
            rd_word[`TSC_WAVE_EN] = wave_enable_q;
            rd_word[`TSC_WAVE_TYPE_LSB +: 2] = wave_type;
         end
         // Stale data is returned as is; reading early is the host's fault
         `TSC_OFS_MEAS: rd_word = meas_data_q;
         `TSC_OFS_ERR: rd_word = err_code_q;
         default: rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `TSC_RST_WORD;
         s_axi_rresp <= `TSC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= mapped(s_axi_araddr) ? `TSC_RESP_OKAY
                                             : `TSC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : tsc_trigger_ctrl

// ===== verif/tsc_trigger_ctrl_monitor.sv
// Purpose: Port-level checks of the trigger state control block.
// Assumes: Bound to tsc_trigger_ctrl, one clock, sync reset.
// Notes: Start/stop timing allows either edge after the bus write.
`timescale 1ns/100ps
module tsc_trigger_ctrl_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [3:0] grp_start_q,
   input wire logic [3:0] grp_stop_q,
   input wire logic sync_active,
   input wire logic wave_enable_q
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // Assertions
   aw_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no bvalid");
   ar_resp_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("no rvalid");
   bus_block_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write taken early");
   start_pulse_a: assert property (
      (grp_start_q & $past(grp_start_q)) == 4'h0) else $error("long start");
   start_cause_a: assert property (|grp_start_q |->
      s_axi_bvalid || $past(s_axi_bvalid)) else $error("start w/o command");
   stop_cause_a: assert property (|grp_stop_q |->
      s_axi_bvalid || $past(s_axi_bvalid)) else $error("stop w/o command");
   stop_pulse_a: assert property (|grp_stop_q |=>
      grp_stop_q == 4'h0) else $error("long stop");
   wave_lock_a: assert property (sync_active |=>
      $stable(wave_enable_q)) else $error("wave enable moved in sync");
   cover property (grp_start_q == 4'h3);
   cover property (grp_stop_q == 4'hF);
   cover property (sync_active && s_axi_bvalid);
endmodule : tsc_trigger_ctrl_monitor

bind tsc_trigger_ctrl tsc_trigger_ctrl_monitor tsc_trigger_ctrl_monitor_i (.*);

// ===== verif/tsc_engine_model.sv
// Purpose: Behavioural engines behind the four trigger groups.
// Assumes: One-cycle start and stop pulses from the block.
// Notes: Data line toggles outside the done cycle on purpose.
`timescale 1ns/100ps
module tsc_engine_model (
   input wire logic aclk,
   input wire logic [3:0] start,
   input wire logic [3:0] stop,
   input wire logic hold,
   input wire logic slow,
   output logic [3:0] done,
   output logic [31:0] value
);
   logic [3:0] busy;
   logic [2:0] t;
   logic [15:0] n;
   logic go;
   initial begin
      busy = 4'h0;
      t = 3'h0;
      n = 16'h0;
      done = 4'h0;
      value = 32'h0;
   end
   // Hold keeps an engine running so cancels hit it mid-way
   assign go = !hold && (!slow || t == 3'h0);
   always @(posedge aclk) begin
      t <= t + 3'h1;
      busy <= (busy | start) & ~stop & ~done;
      done <= busy & ~done & ~stop & {4{go}};
      value <= (busy[1] && !done[1] && go) ? 32'h00A50000 + 32'(n) : ~value;
      if (done[1]) n <= n + 16'h1;
   end
endmodule : tsc_engine_model

// ===== verif/testbench.sv
// Purpose: Self-checking bench of the trigger state control block.
// Assumes: AXI4-Lite master tasks, engine model on the far side.
// Notes: Seeded random pending settings.
`timescale 1ns/100ps
`include "tsc_params.svh"
module testbench;
   localparam logic [2:0] SI = tsc_pkg::ST_IDLE;
   localparam logic [2:0] SN = tsc_pkg::ST_INIT;
   localparam logic [2:0] SW = tsc_pkg::ST_WAITING_FOR_TRIGGER_STATE;
   logic aclk = 0, aresetn = 0, hold = 0, slow = 0, sync_active = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, meas_value;
   logic [31:0] out_ac_q, out_dc_q, out_freq_q, rdata_seen, seed;
   logic [3:0] s_axi_wstrb = 0, grp_start_q, grp_stop_q, grp_done;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, wave_enable_q;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp_seen, wave_type = 0;
   logic [31:0] ns[4] = '{default: 0}, np[4] = '{default: 0};
   logic [31:0] es[4] = '{default: 0}, ep[4] = '{default: 0};
   logic [31:0] pv[3], ov[3];
   int err_count = 0, num_checks = 0;
   tsc_trigger_ctrl tsc_trigger_ctrl_i (.*);
   tsc_engine_model tsc_engine_model_i (.aclk(aclk), .start(grp_start_q),
      .stop(grp_stop_q), .hold(hold), .slow(slow), .done(grp_done),
      .value(meas_value));
   initial forever #12.5 aclk = ~aclk;
   always @(posedge aclk) begin
      for (int g = 0; g < 4; g++) begin
         ns[g] <= ns[g] + 32'(grp_start_q[g]);
         np[g] <= np[g] + 32'(grp_stop_q[g]);
      end
   end
   // ==========================================================
   // Helpers
   function logic [31:0] st(input logic [11:0] g, input logic [4:0] h);
      return {15'h0, h, g};
   endfunction : st
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Handshakes and answers are all judged at the rising edge
   task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      logic kr;
      kr = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= we;
      s_axi_wvalid <= we;
      s_axi_bready <= we;
      s_axi_arvalid <= !we;
      s_axi_rready <= !we;
      while (!kr) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_arready) s_axi_arvalid <= 0;
         kr = we ? s_axi_bvalid : s_axi_rvalid;
      end
      rdata_seen = s_axi_rdata;
      resp_seen = we ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 0;
      s_axi_rready <= 0;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      check(rdata_seen, e);
   endtask : rc
   // Engine latency bound, slow mode included
   task settle;
      repeat (24) @(posedge aclk);
   endtask : settle
   task new_pend;
      for (int k = 0; k < 3; k++) begin
         pv[k] = $random(seed);
         wr(8'(8 + 4 * k), pv[k]);
      end
   endtask : new_pend
   task give_verdict;
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      give_verdict;
   end
   // ==========================================================
   // Scenarios
   initial begin
      seed = 32'h8892;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      rc(`TSC_OFS_STATUS, st(12'h249, 5'h0));
      rc(8'h30, 32'h0);
      check({30'h0, resp_seen}, {30'h0, `TSC_RESP_SLVERR});
      for (int g = 0; g < 4; g++) begin
         new_pend;
         if (g == 0) ov = pv;
         wr(`TSC_OFS_CMD, 32'h1 << g);
         es[g]++;
         settle;
      end
      check(out_ac_q, ov[0]);
      check(out_dc_q, ov[1]);
      check(out_freq_q, ov[2]);
      rc(`TSC_OFS_STATUS, st(12'h249, 5'h1));
      rc(`TSC_OFS_MEAS, 32'h00A50000);
      wr(`TSC_OFS_CMD, 32'h1F0);
      settle;
      for (int g = 0; g < 4; g++) check(ns[g], es[g]);
      slow <= 1;
      wr(`TSC_OFS_SRC, 32'hF);
      wr(`TSC_OFS_CMD, 32'h7);
      rc(`TSC_OFS_STATUS, st({SI, SW, SW, SW}, 5'h1));
      check(out_ac_q, ov[0]);
      wr(`TSC_OFS_CMD, 32'h040);
      es[2]++;
      settle;
      rc(`TSC_OFS_STATUS, st({SI, SI, SW, SW}, 5'h1));
      wr(`TSC_OFS_CMD, 32'h100);
      es[0]++;
      es[1]++;
      settle;
      check(out_ac_q, pv[0]);
      check(out_freq_q, pv[2]);
      rc(`TSC_OFS_MEAS, 32'h00A50001);
      ov = pv;
      hold <= 1;
      wr(`TSC_OFS_SRC, 32'h7);
      new_pend;
      wr(`TSC_OFS_CMD, 32'hF);
      es[3]++;
      rc(`TSC_OFS_STATUS, st({SN, SW, SW, SW}, 5'h1));
      wr(`TSC_OFS_CMD, 32'h200);
      for (int g = 0; g < 4; g++) ep[g]++;
      rc(`TSC_OFS_STATUS, st(12'h249, 5'h1));
      rc(`TSC_OFS_PEND_AC, ov[0]);
      wr(`TSC_OFS_SRC, 32'h0);
      wr(`TSC_OFS_CMD, 32'h3);
      es[0]++;
      es[1]++;
      wr(`TSC_OFS_CMD, 32'h10);
      rc(`TSC_OFS_STATUS, st({SI, SI, SN, SN}, 5'h3));
      rc(`TSC_OFS_ERR, `TSC_ERR_TRIGGER);
      wr(`TSC_OFS_CMD, 32'h1000);
      ep[0]++;
      ep[1]++;
      rc(`TSC_OFS_STATUS, st(12'h249, 5'h3));
      rc(`TSC_OFS_MEAS, 32'h00A50001);
      wr(`TSC_OFS_STATUS, 32'h2000);
      wr(`TSC_OFS_ERR, 32'h0);
      hold <= 0;
      wr(`TSC_OFS_SRC, 32'h2);
      for (int k = 0; k < 2; k++) begin
         wr(`TSC_OFS_CMD, 32'h2000);
         es[1]++;
         settle;
         rc(`TSC_OFS_MEAS, 32'h00A50002 + 32'(k));
         wr(`TSC_OFS_CMD, 32'h400 << k);
         xfer(1'b0, `TSC_OFS_MEAS, 32'h0);
         rc(`TSC_OFS_STATUS, st(12'h249, 5'h4));
         rc(`TSC_OFS_ERR, `TSC_ERR_NO_DATA);
         wr(`TSC_OFS_STATUS, 32'h4000);
         wr(`TSC_OFS_ERR, 32'h0);
      end
      for (int k = 0; k < 4; k++) begin
         wave_type <= 2'(k);
         wr(`TSC_OFS_WAVE, 32'h1);
         rc(`TSC_OFS_WAVE, 32'h1 | 32'(k << 4));
      end
      sync_active <= 1;
      wr(`TSC_OFS_WAVE, 32'h0);
      rc(`TSC_OFS_WAVE, 32'h31);
      check({31'h0, wave_enable_q}, 32'h1);
      rc(`TSC_OFS_STATUS, st(12'h249, 5'h18));
      for (int g = 0; g < 4; g++) begin
         check(ns[g], es[g]);
         check(np[g], ep[g]);
      end
      give_verdict;
   end
endmodule : testbench
